// [rtl/digipot_defs.svh]
// Purpose: Named constants for the two-wire digital potentiometer slave.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only; no logic lives here.
`ifndef DIGIPOT_DEFS_SVH
`define DIGIPOT_DEFS_SVH

// Device type code in the upper nibble of the slave address (value is arbitrary).
`define DP_TYPE_CODE 4'ha
// Slave address byte fields.
`define DP_TYPE_MSB 7
`define DP_TYPE_LSB 4
`define DP_GND_BIT 3
`define DP_SEL_MSB 2
`define DP_SEL_LSB 0
// Command byte fields.
`define DP_OP_MSB 7
`define DP_OP_LSB 5
`define DP_IDX_MSB 3
`define DP_IDX_LSB 0
// Command opcodes.
`define DP_OP_RD_REG 3'h4
`define DP_OP_WR_REG 3'h6
`define DP_OP_RD_WIPER 3'h5
`define DP_OP_WR_WIPER 3'h7
// Bit counter values within a nine-clock byte slot.
`define DP_CNT_ZERO 4'h0
`define DP_CNT_ONE 4'h1
`define DP_CNT_LAST 4'h7
`define DP_CNT_ACK 4'h8
// Storage sizes and reset values.
`define DP_NV_REGS 16
`define DP_DEFAULT_REG 4'h0
`define DP_NV_INIT 8'h80
`define DP_WIPER_RST 8'h00
`define DP_BYTE_ZERO 8'h00
`define DP_TAP_ONE 256'h1

`endif

// [rtl/digipot_pkg.sv]
// Purpose: Types shared by the potentiometer slave.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes: Bus states follow a Gray sequence along the normal transfer path.
package digipot_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_cmd = 3'b011,
        st_wdata = 3'b010,
        st_rdata = 3'b111,
        st_ignore = 3'b110
    } state_t;
endpackage : digipot_pkg

// [rtl/digipot_two_wire_slave.sv]
// Purpose: Two-wire slave controlling a 256-tap digital potentiometer.
// Assumes: Bus pins arrive synchronous to i_core_clk; the clock is many times faster than SCL.
// Notes: Frame is address byte, command byte, then one data byte written, or data bytes read until the master does not acknowledge.
// Operation
// - A 255-element array offers 256 taps, exactly one tap on the wiper.
// - The volatile wiper position register alone selects the connected tap.
// - After power-up the default stored register is copied into the wiper register.
// - Sixteen retained data registers are readable and writable over the bus.
// - Incoming bits are sampled on each rising serial clock edge.
// - Transmitted data changes only after falling serial clock edges, one bit per clock.
// - Serial data is open-drain; the device only pulls low or releases.
// - Address select pins form the low three bits of the slave address.
// - Only a matching slave address engages the device; otherwise it stays off the bus.
// - The upper address nibble must equal the built-in device type code.
// - The 8-bit wiper register is decoded to one of 256 tap switches.
// - A low write-protect input blocks every retained data register write.
// - Acknowledge is pulled low on the ninth clock after address, command and data.
`timescale 1ns/1ps
`include "digipot_defs.svh"
module digipot_two_wire_slave (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Two-wire bus pins.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Straps and protection.
    input wire logic [2:0] i_address_select_pins,
    input wire logic i_grounded_address_pin,
    input wire logic i_wp_n,
    // Potentiometer side.
    output logic [255:0] o_tap_sel,
    output logic [7:0] o_wiper_position
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus event detection.

    digipot_pkg::state_t state_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] tx_q;
    logic [7:0] wiper_q;
    logic ack_q;
    logic recall_q;
    logic [7:0] nv_q [0:`DP_NV_REGS-1];

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic slot_end;
    logic [7:0] rx_byte;
    logic addr_hit;
    logic op_valid;
    logic wr_reg;
    logic wr_wiper;
    logic [7:0] rd_value;

    // The clock pin is only ever looked at, never driven.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= i_scl;
            sda_prev_q <= i_sda;
        end
    end

    // Edge and condition decode; start and stop are data moves while the clock is high.
    assign scl_rise = i_scl & ~scl_prev_q;
    assign scl_fall = ~i_scl & scl_prev_q;
    assign bus_start = i_scl & scl_prev_q & sda_prev_q & ~i_sda;
    assign bus_stop = i_scl & scl_prev_q & ~sda_prev_q & i_sda;
    assign slot_end = scl_rise & (cnt_q == `DP_CNT_ACK);
    assign rx_byte = {shift_q[6:0], i_sda};

    // Address compare: type nibble, grounded pin and strap pins must all agree.
    assign addr_hit = (rx_byte[`DP_TYPE_MSB:`DP_TYPE_LSB] == `DP_TYPE_CODE) &&
        (rx_byte[`DP_GND_BIT] == i_grounded_address_pin) &&
        (rx_byte[`DP_SEL_MSB:`DP_SEL_LSB] == i_address_select_pins);

    // Only the four implemented opcodes are acknowledged.
    assign op_valid = (rx_byte[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_RD_REG) ||
        (rx_byte[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_WR_REG) ||
        (rx_byte[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_RD_WIPER) ||
        (rx_byte[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_WR_WIPER);

    // Write strobes fire on the rising edge of the data byte's acknowledge clock.
    assign wr_reg = slot_end && (state_q == digipot_pkg::st_wdata) &&
        (cmd_q[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_WR_REG);
    assign wr_wiper = slot_end && (state_q == digipot_pkg::st_wdata) &&
        (cmd_q[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_WR_WIPER);

    // Read source follows the command just received, or the stored one on repeats.
    always_comb begin
        rd_value = wiper_q;
        if (state_q == digipot_pkg::st_cmd) begin
            if (shift_q[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_RD_REG) begin
                rd_value = nv_q[shift_q[`DP_IDX_MSB:`DP_IDX_LSB]];
            end
        end else if (cmd_q[`DP_OP_MSB:`DP_OP_LSB] == `DP_OP_RD_REG) begin
            rd_value = nv_q[cmd_q[`DP_IDX_MSB:`DP_IDX_LSB]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path and transaction state.

    // Bits shift in on rising edges; the nine-clock slot closes on the ninth rise.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= digipot_pkg::st_idle;
            cnt_q <= `DP_CNT_ZERO;
            shift_q <= `DP_BYTE_ZERO;
            cmd_q <= `DP_BYTE_ZERO;
            ack_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= digipot_pkg::st_idle;
            ack_q <= 1'b0;
        end else if (bus_start) begin
            state_q <= digipot_pkg::st_addr;
            cnt_q <= `DP_CNT_ZERO;
            ack_q <= 1'b0;
        end else if (scl_rise && state_q != digipot_pkg::st_idle &&
                state_q != digipot_pkg::st_ignore) begin
            if (cnt_q == `DP_CNT_ACK) begin
                cnt_q <= `DP_CNT_ZERO;
                ack_q <= 1'b0;
                case (state_q)
                    digipot_pkg::st_addr: begin
                        state_q <= ack_q ? digipot_pkg::st_cmd : digipot_pkg::st_ignore;
                    end
                    digipot_pkg::st_cmd: begin
                        cmd_q <= shift_q;
                        if (!ack_q) begin
                            state_q <= digipot_pkg::st_ignore;
                        end else if (shift_q[`DP_OP_LSB+1]) begin
                            state_q <= digipot_pkg::st_wdata;
                        end else begin
                            state_q <= digipot_pkg::st_rdata;
                        end
                    end
                    digipot_pkg::st_rdata: begin
                        // A master that does not acknowledge ends the read.
                        state_q <= i_sda ? digipot_pkg::st_ignore : digipot_pkg::st_rdata;
                    end
                    default: begin
                        state_q <= digipot_pkg::st_ignore;
                    end
                endcase
            end else begin
                shift_q <= rx_byte;
                cnt_q <= cnt_q + `DP_CNT_ONE;
                if (cnt_q == `DP_CNT_LAST) begin
                    case (state_q)
                        digipot_pkg::st_addr: ack_q <= addr_hit;
                        digipot_pkg::st_cmd: ack_q <= op_valid;
                        digipot_pkg::st_wdata: ack_q <= 1'b1;
                        default: ack_q <= 1'b0;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path and open-drain data pin.

    // Pin changes only on falling clock edges, except release at start or stop.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sda_oe <= 1'b0;
            tx_q <= `DP_BYTE_ZERO;
        end else if (bus_stop || bus_start) begin
            o_sda_oe <= 1'b0;
        end else if (slot_end && (state_q == digipot_pkg::st_cmd ||
                state_q == digipot_pkg::st_rdata)) begin
            tx_q <= rd_value;
        end else if (scl_fall) begin
            case (state_q)
                digipot_pkg::st_rdata: begin
                    if (cnt_q == `DP_CNT_ACK) begin
                        o_sda_oe <= 1'b0;
                    end else begin
                        o_sda_oe <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                digipot_pkg::st_addr, digipot_pkg::st_cmd, digipot_pkg::st_wdata: begin
                    o_sda_oe <= (cnt_q == `DP_CNT_ACK) && ack_q;
                end
                default: begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // The data output only ever pulls low; the pull-up makes the high level.
    assign o_sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Retained data registers and wiper.

    // Reset stands for power-up here, so every register starts from DP_NV_INIT, not from earlier writes.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < `DP_NV_REGS; i++) begin
                nv_q[i] <= `DP_NV_INIT;
            end
        end else if (wr_reg && i_wp_n) begin
            nv_q[cmd_q[`DP_IDX_MSB:`DP_IDX_LSB]] <= shift_q;
        end
    end

    // Recall runs one cycle after reset release, since a flop cannot load a signal in reset.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            recall_q <= 1'b1;
            wiper_q <= `DP_WIPER_RST;
        end else begin
            recall_q <= 1'b0;
            if (recall_q) begin
                wiper_q <= nv_q[`DP_DEFAULT_REG];
            end else if (wr_wiper) begin
                wiper_q <= shift_q;
            end
        end
    end

    // One-hot tap decode, registered so the switch bank sees clean levels.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tap_sel <= `DP_TAP_ONE;
        end else begin
            o_tap_sel <= `DP_TAP_ONE << wiper_q;
        end
    end

    assign o_wiper_position = wiper_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_tap_onehot: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $onehot(o_tap_sel)) else $error("tap select is not one-hot");

    chk_tap_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ##1 o_tap_sel == (`DP_TAP_ONE << $past(wiper_q))) else $error("tap does not track wiper");

    chk_wiper_cause: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(wiper_q) |-> $past(recall_q) || $past(wr_wiper)) else $error("wiper moved alone");

    chk_power_recall: assert property (@(posedge i_core_clk) disable iff (i_rst)
        recall_q |=> wiper_q == $past(nv_q[`DP_DEFAULT_REG])) else $error("recall missed");

    chk_sample_rise: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(shift_q) |-> $past(scl_rise)) else $error("bit taken off a rising edge");

    chk_drive_fall: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_sda_oe) |-> $past(scl_fall)) else $error("data driven off a falling edge");

    chk_pull_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_sda_o == 1'b0) else $error("data pin driven high");

    chk_addr_match: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == digipot_pkg::st_addr && scl_rise && cnt_q == `DP_CNT_LAST && !bus_stop &&
        !bus_start) |=> ack_q == ({$past(shift_q[6:0]), $past(i_sda)} ==
        {`DP_TYPE_CODE, $past(i_grounded_address_pin), $past(i_address_select_pins)}))
        else $error("address compare wrong");

    chk_idle_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == digipot_pkg::st_idle) |-> !o_sda_oe) else $error("drives bus while idle");

    chk_wp_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_reg && !i_wp_n) |=> nv_q[$past(cmd_q[`DP_IDX_MSB:`DP_IDX_LSB])] ==
        $past(nv_q[cmd_q[`DP_IDX_MSB:`DP_IDX_LSB]])) else $error("protected write landed");

    chk_ack_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (scl_fall && ack_q && cnt_q == `DP_CNT_ACK && !bus_start && !bus_stop &&
        state_q != digipot_pkg::st_rdata) |=> o_sda_oe) else $error("acknowledge missing");

endmodule : digipot_two_wire_slave

// [bench/two_wire_master.sv]
// Purpose: Behavioural bus master that drives the serial clock and data for the slave bench.
// Assumes: Signals change on the falling core clock edge; the data line has a pull-up.
// Notes: One transfer task covers both directions; a released line reads high.
`timescale 1ns/1ps
module two_wire_master (
    // Core clock used only for pacing.
    input wire logic i_core_clk,
    // Resolved data line level.
    input wire logic i_sda,
    // Bus drive.
    output logic o_scl,
    output logic o_sda_low
);
    ////////////////////////////////////////////////////////////////////////////////
    // The master owns the clock and idles the bus released.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Waits a number of falling core edges.
    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : tick

    // Start, also usable as a repeated start while the clock is low.
    task automatic start();
        o_sda_low = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b1;
        tick(4);
        o_scl = 1'b0;
        tick(2);
    endtask : start

    // Stop raises data while the clock is high.
    task automatic stop();
        o_sda_low = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b0;
        tick(4);
    endtask : stop

    // One clock: data set while low, sampled mid high phase.
    task automatic clk_bit(input logic b, output logic s);
        o_sda_low = ~b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        s = i_sda;
        tick(2);
        o_scl = 1'b0;
        tick(2);
    endtask : clk_bit

    // Eight data clocks then the acknowledge clock, most significant bit first.
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(ack_in, ack_out);
    endtask : xfer
endmodule : two_wire_master

// [bench/tb.sv]
// Purpose: Self-checking bench for the potentiometer two-wire slave.
// Assumes: Core clock 40 MHz; bus clock eight core cycles per bit.
// Notes: Expectations come from the shared constants, never from design outputs.
`timescale 1ns/1ps
`include "digipot_defs.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic sda_low;
    logic sda;
    logic sda_o;
    logic sda_oe;
    logic [2:0] straps = 3'h5;
    logic gnd_pin = 1'b0;
    logic wp_n = 1'b1;
    logic [255:0] tap_sel;
    logic [7:0] wiper;
    int err_count = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and the wired-AND data line with its pull-up.
    initial begin
        forever #12.5 clk = ~clk;
    end
    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    digipot_two_wire_slave DUT (.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_address_select_pins(straps),
        .i_grounded_address_pin(gnd_pin), .i_wp_n(wp_n), .o_tap_sel(tap_sel),
        .o_wiper_position(wiper));
    two_wire_master master (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] addr(input logic [2:0] sel);
        return {`DP_TYPE_CODE, 1'b0, sel};
    endfunction : addr

    // Acks come back as 0 for acknowledged bytes.
    task automatic frame_wr(input logic [7:0] a, c, d, output logic [2:0] acks);
        logic [7:0] rx;
        master.start();
        master.xfer(a, 1'b1, rx, acks[2]);
        master.xfer(c, 1'b1, rx, acks[1]);
        master.xfer(d, 1'b1, rx, acks[0]);
        master.stop();
    endtask : frame_wr

    // The master releases the line while reading, acknowledges once to hear the value again,
    // then ends with a no-acknowledge. A repeat that differs poisons the result on purpose.
    task automatic frame_rd(input logic [7:0] a, c, output logic [7:0] d, output logic [1:0] acks);
        logic nack;
        logic [7:0] again;
        master.start();
        master.xfer(a, 1'b1, d, acks[1]);
        master.xfer(c, 1'b1, d, acks[0]);
        master.xfer(8'hff, 1'b0, d, nack);
        master.xfer(8'hff, 1'b1, again, nack);
        master.stop();
        if (again !== d) begin
            d = 8'hxx;
        end
    endtask : frame_rd

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_power_up();
        @(negedge clk);
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(wiper, `DP_NV_INIT);
        check(tap_sel, `DP_TAP_ONE << `DP_NV_INIT);
        $display("Test power_up done");
    endtask : t_power_up

    // Boundary wiper values and one mid value, each read back over the bus.
    task automatic t_wiper();
        logic [7:0] vals [3] = '{8'h00, 8'hff, 8'h3c};
        logic [2:0] a3;
        logic [1:0] a2;
        logic [7:0] d;
        foreach (vals[i]) begin
            frame_wr(addr(straps), {`DP_OP_WR_WIPER, 5'h00}, vals[i], a3);
            check(a3, 3'b000);
            repeat (2) @(negedge clk);
            check(wiper, vals[i]);
            check(tap_sel, `DP_TAP_ONE << vals[i]);
            frame_rd(addr(straps), {`DP_OP_RD_WIPER, 5'h00}, d, a2);
            check(a2, 2'b00);
            check(d, vals[i]);
        end
        $display("Test wiper done");
    endtask : t_wiper

    // Stored registers, then a write of new data to the same register blocked by write protect.
    task automatic t_regs();
        logic [2:0] a3;
        logic [1:0] a2;
        logic [7:0] d;
        frame_wr(addr(straps), {`DP_OP_WR_REG, 5'h0f}, 8'h5a, a3);
        check(a3, 3'b000);
        frame_rd(addr(straps), {`DP_OP_RD_REG, 5'h0f}, d, a2);
        check(d, 8'h5a);
        frame_rd(addr(straps), {`DP_OP_RD_REG, 5'h00}, d, a2);
        check(d, `DP_NV_INIT);
        check(wiper, 8'h3c);
        @(negedge clk);
        wp_n = 1'b0;
        frame_wr(addr(straps), {`DP_OP_WR_REG, 5'h0f}, 8'h11, a3);
        check(a3, 3'b000);
        frame_rd(addr(straps), {`DP_OP_RD_REG, 5'h0f}, d, a2);
        check(d, 8'h5a);
        @(negedge clk);
        wp_n = 1'b1;
        $display("Test regs done");
    endtask : t_regs

    // Wrong straps, wrong type code and a set grounded bit must all be ignored.
    task automatic t_addr();
        logic [7:0] bad [3];
        logic [2:0] a3;
        @(negedge clk);
        straps = 3'h2;
        bad = '{addr(3'h5), addr(3'h2) ^ 8'h50, addr(3'h2) | 8'h08};
        foreach (bad[i]) begin
            frame_wr(bad[i], {`DP_OP_WR_WIPER, 5'h00}, 8'h77, a3);
            check(a3, 3'b111);
            check(wiper, 8'h3c);
        end
        frame_wr(addr(3'h2), {`DP_OP_WR_WIPER, 5'h00}, 8'h77, a3);
        check(a3, 3'b000);
        repeat (2) @(negedge clk);
        check(wiper, 8'h77);
        // An unknown opcode is refused: address acknowledged, command and data not.
        frame_wr(addr(3'h2), {3'h0, 5'h00}, 8'h55, a3);
        check(a3, 3'h3);
        check(wiper, 8'h77);
        straps = 3'h5;
        $display("Test addr done");
    endtask : t_addr

    ////////////////////////////////////////////////////////////////////////////////
    // Closing, main sequence and watchdog.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        t_power_up();
        t_wiper();
        t_regs();
        t_addr();
        t_power_up();
        complete_run();
    end

    // About 16 frames of 300 cycles are expected; this allows about eight times that.
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule : tb
